/* File: verilog/core_exec_pkg.sv */
// Constants, register map and helpers shared by the instruction execution core
package core_exec_pkg;

    // Avalon register byte offsets
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_CORE = 4'h4;
    localparam logic [3:0] OFF_ACC  = 4'h8;

    // Control register fields and reset value
    localparam int         CTRL_PSEL_LSB = 0;
    localparam int         CTRL_RUN_BIT  = 2;
    localparam int         CTRL_WDT_BIT  = 3;
    localparam logic [7:0] CTRL_RST      = 8'h00;

    // Core status word fields
    localparam int CORE_PC_LSB    = 0;
    localparam int CORE_SLEEP_BIT = 16;
    localparam int CORE_INTEN_BIT = 17;
    localparam int CORE_SP_LSB    = 18;

    // Accumulator word fields
    localparam int ACCW_A_LSB = 0;
    localparam int ACCW_F_LSB = 8;

    // Last phase index of an instruction cycle per period select code
    localparam logic [3:0] PHASE_LAST_00 = 4'h3;
    localparam logic [3:0] PHASE_LAST_01 = 4'h1;
    localparam logic [3:0] PHASE_LAST_10 = 4'h7;
    localparam logic [3:0] PHASE_LAST_11 = 4'hF;

    // Register file addresses with special meaning
    localparam logic [5:0] RA_PC      = 6'h02;
    localparam logic [5:0] RA_STATUS  = 6'h03;
    localparam logic [5:0] RA_BANK    = 6'h04;
    localparam logic [5:0] RA_TBL_LO  = 6'h05;
    localparam logic [5:0] RA_TBL_HI  = 6'h06;
    localparam int         TBL_SEL_BIT = 7;

    // Status register bit positions
    localparam int ST_C = 0;
    localparam int ST_H = 1;
    localparam int ST_Z = 2;
    localparam int ST_P = 3;
    localparam int ST_T = 4;

    // Reset values
    localparam logic [12:0] PC_RST   = 13'h0000;
    localparam logic [12:0] IR_IDLE  = 13'h0000;
    localparam logic [2:0]  SP_RST   = 3'h0;

    // Watchdog span in instruction cycles
    localparam logic [11:0] WDT_LAST = 12'hF9F;

    // Returns {carry, digit carry, sum}
    function automatic logic [9:0] add8(input logic [7:0] x,
                                        input logic [7:0] y,
                                        input logic       ci);
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
        n = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
        return {s[8], n[4], s[7:0]};
    endfunction : add8

endpackage : core_exec_pkg

/* File: verilog/core_exec.sv */
// Instruction decode and execution core with Avalon control port
// Notes on behaviour
// - Instruction words are 13 bits: opcode plus register, bit or literal fields.
// - Each instruction normally completes in one instruction cycle.
// - Any write to the program counter register costs two instruction cycles.
// - Long jump/call, table read, exits and taken skips take two cycles.
// - Cycle length code 01 gives two clocks, 00 gives four clocks.
// - Bit instructions test any register bit directly, and set or clear any bit except status bits 7..3.
// - Port registers are ordinary operands for register instructions.
// - Port control write/read act only on control registers 5-7 and A-F.
// - Sleep op clears watchdog and stops; watchdog clear op only clears; both set T; clear sets P, sleep clears P.
// - Exits pop the stack; interrupt exit enables interrupts; literal exit loads A.
// - Rotates move an end bit into carry and old carry in; only carry changes.
// - Decrement/increment-and-skip write result, skip on zero, flags untouched.
// - Literals are 8 bits, or 10 bits with current page for call and jump.
// - Period select 00/01/10/11 gives 4/2/8/16 clocks per instruction.
// - Long call and jump take the target from the next word; call pushes first.
// - Table read returns bits 7..0, or bits 12..8 zero-extended when select set.
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module core_exec
(
    input  wire logic        clk,             // Core oscillator clock
    input  wire logic        rst_b,           // Asynchronous reset, active low
    input  wire logic [3:0]  avs_address,     // Avalon byte address
    input  wire logic        avs_read,        // Avalon read request
    input  wire logic        avs_write,       // Avalon write request
    input  wire logic [3:0]  avs_byteenable,  // Avalon byte enables
    input  wire logic [31:0] avs_writedata,   // Avalon write data
    output logic      [31:0] avs_readdata,    // Avalon read data
    output logic             avs_waitrequest, // Avalon wait request
    output logic      [12:0] pmem_addr,       // Instruction fetch address
    input  wire logic [12:0] pmem_data,       // Fetched word, valid one clock after address
    output logic      [12:0] tbl_addr,        // Table read address
    input  wire logic [12:0] tbl_data,        // Table read word
    input  wire logic        wake_pin,        // Asynchronous wake request, active high
    output logic             sleep_out,       // Core stopped by sleep op
    output logic             int_enable,      // Interrupt enable state
    output logic             wdt_timeout,     // One-clock watchdog expiry pulse
    output logic             cycle_end        // One-clock pulse at each executed cycle end
);
    import core_exec_pkg::*;

    logic [12:0] pc_r;
    logic [12:0] ir_r;
    logic [7:0]  acc_r;
    logic        carry_r;
    logic        digit_carry_flag_r;
    logic        zero_r;
    logic        tflag_r;
    logic        pflag_r;
    logic [2:0]  sp_r;
    logic [3:0]  phase_r;
    logic [7:0]  ctrl_r;
    logic        sleep_r;
    logic        int_en_r;
    logic [7:0]  cont_r;
    logic [11:0] wdt_cnt_r;
    logic        wdt_to_r;
    logic        cyc_end_r;
    logic        wake_s1_r;
    logic        wake_s2_r;
    logic        wait_r;
    logic [31:0] rdata_r;
    logic [12:0] tbl_addr_r;
    logic        tbl_pend_r;
    logic [5:0]  tbl_dst_r;
    logic [7:0]  rf    [0:63];
    logic [7:0]  ioc   [0:15];
    logic [12:0] stack [0:7];

    // Cycle timing
    wire  [1:0]  psel       = ctrl_r[CTRL_PSEL_LSB +: 2];
    wire  [3:0]  phase_last = (psel == 2'h0) ? PHASE_LAST_00 :
                              (psel == 2'h1) ? PHASE_LAST_01 :
                              (psel == 2'h2) ? PHASE_LAST_10 : PHASE_LAST_11;
    wire         cyc_last   = (phase_r == phase_last);
    wire         ex         = cyc_last & ctrl_r[CTRL_RUN_BIT] & ~sleep_r;
    wire         wdt_hit    = cyc_last & ctrl_r[CTRL_WDT_BIT] & (wdt_cnt_r == WDT_LAST);

    // Operand fields
    wire         bank_op = (ir_r[12:4] == 9'h1E9);
    wire  [5:0]  rsel    = bank_op ? RA_BANK : ir_r[5:0];
    wire  [2:0]  bsel    = ir_r[8:6];
    wire  [7:0]  bmask   = 8'h01 << bsel;
    wire  [7:0]  lit8    = ir_r[7:0];
    wire  [12:0] pc_cur  = pc_r - 13'h0001;
    wire  [7:0]  status  = {3'h0, tflag_r, pflag_r, zero_r, digit_carry_flag_r, carry_r};
    wire  [7:0]  rv      = (rsel == RA_PC)     ? pc_cur[7:0] :
                           (rsel == RA_STATUS) ? status : rf[rsel];
    wire  [3:0]  ioc_idx = ir_r[3:0];
    wire         ioc_ok  = (ioc_idx >= 4'h5 && ioc_idx <= 4'h7) || (ioc_idx >= 4'hA);
    wire  [12:0] stk_top = stack[sp_r - 3'h1];
    wire  [7:0]  tbl_hi  = rf[RA_TBL_HI];

    // Execute results
    logic [7:0]  res;
    logic        wr_a;
    logic        wr_r;
    logic        set_z;
    logic        c_new;
    logic        h_new;
    logic        skip;
    logic        jump;
    logic [12:0] tgt;
    logic        push;
    logic [12:0] push_val;
    logic        pop;
    logic        wdt_clr;
    logic        go_sleep;
    logic        ien_set;
    logic        ien_clr;
    logic        cont_wr;
    logic        ioc_wr;
    logic        tbl_go;
    logic [9:0]  sum;
    logic [7:0]  adj;

    always_comb
    begin
        res = 8'h00; wr_a = 1'b0; wr_r = 1'b0; set_z = 1'b0;
        c_new = carry_r; h_new = digit_carry_flag_r; skip = 1'b0; jump = 1'b0;
        tgt = pc_r; push = 1'b0; push_val = pc_r; pop = 1'b0; wdt_clr = 1'b0;
        go_sleep = 1'b0; ien_set = 1'b0; ien_clr = 1'b0; cont_wr = 1'b0;
        ioc_wr = 1'b0; tbl_go = 1'b0; sum = 10'h000;
        adj = {((acc_r > 8'h99) | carry_r) ? 4'h6 : 4'h0,
               ((acc_r[3:0] > 4'h9) | digit_carry_flag_r) ? 4'h6 : 4'h0};
        if (!ir_r[12] && ir_r[11])
        begin
            case (ir_r[10:9])
                2'h0:    begin res = rv & ~bmask; wr_r = 1'b1; end
                2'h1:    begin res = rv | bmask;  wr_r = 1'b1; end
                2'h2:    skip = ~rv[bsel];
                default: skip = rv[bsel];
            endcase
        end
        else if (!ir_r[12] && ir_r[10:8] == 3'h0)
        begin
            case (ir_r[7:6])
                2'h0:
                begin
                    if (ir_r[5:0] == 6'h01)
                    begin
                        res = acc_r + adj; wr_a = 1'b1; c_new = adj[6];
                    end
                    else if (ir_r[5:0] == 6'h02)
                        cont_wr = 1'b1;
                    else if (ir_r[5:0] == 6'h03)
                    begin
                        wdt_clr = 1'b1; go_sleep = 1'b1;
                    end
                    else if (ir_r[5:0] == 6'h04)
                        wdt_clr = 1'b1;
                    else if (ir_r[5:4] == 2'h0)
                        ioc_wr = ioc_ok;
                    else if (ir_r[5:0] == 6'h10)
                        ien_set = 1'b1;
                    else if (ir_r[5:0] == 6'h11)
                        ien_clr = 1'b1;
                    else if (ir_r[5:1] == 5'h09)
                    begin
                        pop = 1'b1; jump = 1'b1; tgt = stk_top;
                        ien_set = ir_r[0];
                    end
                    else if (ir_r[5:0] == 6'h14)
                    begin
                        res = cont_r; wr_a = 1'b1;
                    end
                    else if (ir_r[5:4] == 2'h1)
                    begin
                        res = ioc[ioc_idx]; wr_a = ioc_ok;
                    end
                end
                2'h1:    begin res = acc_r; wr_r = 1'b1; end
                2'h2:    begin res = 8'h00; wr_a = 1'b1; set_z = 1'b1; end
                default: begin res = 8'h00; wr_r = 1'b1; set_z = 1'b1; end
            endcase
        end
        else if (!ir_r[12])
        begin
            wr_a = ~ir_r[6];
            wr_r = ir_r[6];
            set_z = 1'b1;
            case ({ir_r[10:8], ir_r[7]})
                4'h2:    begin sum = add8(rv, ~acc_r, 1'b1); res = sum[7:0];
                         c_new = sum[9]; h_new = sum[8]; end
                4'h3:    res = rv - 8'h01;
                4'h4:    res = acc_r | rv;
                4'h5:    res = acc_r & rv;
                4'h6:    res = acc_r ^ rv;
                4'h7:    begin sum = add8(acc_r, rv, 1'b0); res = sum[7:0];
                         c_new = sum[9]; h_new = sum[8]; end
                4'h8:    res = rv;
                4'h9:    res = ~rv;
                4'hA:    res = rv + 8'h01;
                4'hB:    begin res = rv - 8'h01; set_z = 1'b0;
                         skip = (res == 8'h00); end
                4'hC:    begin res = {carry_r, rv[7:1]}; c_new = rv[0];
                         set_z = 1'b0; end
                4'hD:    begin res = {rv[6:0], carry_r}; c_new = rv[7];
                         set_z = 1'b0; end
                4'hE:    begin res = {rv[3:0], rv[7:4]}; set_z = 1'b0; end
                default: begin res = rv + 8'h01; set_z = 1'b0;
                         skip = (res == 8'h00); end
            endcase
        end
        else if (!ir_r[11])
        begin
            jump = 1'b1;
            tgt = {pc_r[12:10], ir_r[9:0]};
            push = ~ir_r[10];
        end
        else
        begin
            case (ir_r[11:8])
                4'hC:    begin res = lit8; wr_a = 1'b1; pop = 1'b1;
                         jump = 1'b1; tgt = stk_top; end
                4'hE:
                begin
                    if (ir_r[7:4] == 4'h9)
                    begin
                        res = {ir_r[1:0], rv[5:0]}; wr_r = 1'b1;
                    end
                    else if (ir_r[7:5] == 3'h5)
                    begin
                        jump = 1'b1; tgt = pmem_data;
                        push = ~ir_r[4]; push_val = pc_r + 13'h0001;
                    end
                    else if (ir_r[7:6] == 2'h3)
                    begin
                        tbl_go = 1'b1; jump = 1'b1; tgt = pc_r;
                    end
                end
                4'hD:    begin sum = add8(lit8, ~acc_r, 1'b1); res = sum[7:0];
                         wr_a = 1'b1; set_z = 1'b1; c_new = sum[9]; h_new = sum[8]; end
                4'hF:    begin sum = add8(lit8, acc_r, 1'b0); res = sum[7:0];
                         wr_a = 1'b1; set_z = 1'b1; c_new = sum[9]; h_new = sum[8]; end
                4'h9:    begin res = acc_r | lit8; wr_a = 1'b1; set_z = 1'b1; end
                4'hA:    begin res = acc_r & lit8; wr_a = 1'b1; set_z = 1'b1; end
                4'hB:    begin res = acc_r ^ lit8; wr_a = 1'b1; set_z = 1'b1; end
                default: begin res = lit8; wr_a = 1'b1; end
            endcase
        end
        if (wr_r && rsel == RA_PC)
        begin
            jump = 1'b1;
            tgt = {pc_cur[12:8], res};
        end
        if (skip)
        begin
            jump = 1'b1;
            tgt = pc_r + 13'h0001;
        end
    end

    // Avalon slave: one wait cycle, then a single-cycle answer
    wire        av_req   = avs_read | avs_write;
    wire        av_wr    = avs_write & ~wait_r;
    wire        ctrl_hit = (avs_address == OFF_CTRL);
    wire [31:0] rd_core  = {11'h000, sp_r, int_en_r, sleep_r, 3'h0, pc_r};
    wire [31:0] rd_acc   = {19'h00000, status[4:0], acc_r};
    wire [31:0] rd_mux   = ctrl_hit                   ? {24'h000000, ctrl_r} :
                           (avs_address == OFF_CORE)  ? rd_core :
                           (avs_address == OFF_ACC)   ? rd_acc  : 32'h00000000;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h00000000;
            ctrl_r  <= CTRL_RST;
        end
        else
        begin
            wait_r <= ~(av_req & wait_r);
            // Only a read answer may move read data, so it stands until the next read
            if (avs_read && wait_r)
                rdata_r <= rd_mux;
            if (av_wr && ctrl_hit && avs_byteenable[0])
                ctrl_r <= avs_writedata[7:0];
        end
    end

    // Sequencing, flags and side effects
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase_r <= 4'h0; pc_r <= PC_RST; ir_r <= IR_IDLE; acc_r <= 8'h00;
            carry_r <= 1'b0; digit_carry_flag_r <= 1'b0; zero_r <= 1'b0;
            tflag_r <= 1'b1; pflag_r <= 1'b1; sp_r <= SP_RST; sleep_r <= 1'b0;
            int_en_r <= 1'b0; cont_r <= 8'h00; wdt_cnt_r <= 12'h000; wdt_to_r <= 1'b0;
            cyc_end_r <= 1'b0; wake_s1_r <= 1'b0; wake_s2_r <= 1'b0;
            tbl_addr_r <= 13'h0000; tbl_pend_r <= 1'b0; tbl_dst_r <= 6'h00;
        end
        else
        begin
            wake_s1_r  <= wake_pin;
            wake_s2_r  <= wake_s1_r;
            phase_r    <= cyc_last ? 4'h0 : phase_r + 4'h1;
            cyc_end_r  <= ex;
            wdt_to_r   <= wdt_hit;
            tbl_addr_r <= {tbl_hi[4:0], rf[RA_TBL_LO]};
            if (ex && wdt_clr)
                wdt_cnt_r <= 12'h000;
            else if (cyc_last && ctrl_r[CTRL_WDT_BIT])
                wdt_cnt_r <= wdt_hit ? 12'h000 : wdt_cnt_r + 12'h001;
            if (wdt_hit)
                tflag_r <= 1'b0;
            else if (ex && wdt_clr)
                tflag_r <= 1'b1;
            if (ex && wdt_clr)
                pflag_r <= ~go_sleep;
            if (ex && go_sleep)
                sleep_r <= 1'b1;
            else if (wake_s2_r || wdt_hit)
                sleep_r <= 1'b0;
            if (ex)
            begin
                if (jump)
                begin
                    ir_r <= IR_IDLE;
                    pc_r <= tgt;
                end
                else
                begin
                    ir_r <= pmem_data;
                    pc_r <= pc_r + 13'h0001;
                end
                if (push)
                    sp_r <= sp_r + 3'h1;
                else if (pop)
                    sp_r <= sp_r - 3'h1;
                if (wr_a)
                    acc_r <= res;
                if (wr_r && rsel == RA_STATUS)
                begin
                    carry_r <= res[ST_C]; digit_carry_flag_r <= res[ST_H];
                    zero_r  <= res[ST_Z];
                end
                else
                begin
                    carry_r <= c_new;
                    digit_carry_flag_r <= h_new;
                    if (set_z)
                        zero_r <= (res == 8'h00);
                end
                if (ien_set)
                    int_en_r <= 1'b1;
                else if (ien_clr)
                    int_en_r <= 1'b0;
                if (cont_wr)
                    cont_r <= acc_r;
                tbl_pend_r <= tbl_go;
                tbl_dst_r  <= rsel;
            end
        end
    end

    // Storage arrays carry no reset; software initialises them
    always_ff @(posedge clk)
    begin
        if (ex && tbl_pend_r)
            rf[tbl_dst_r] <= tbl_hi[TBL_SEL_BIT] ? {3'h0, tbl_data[12:8]}
                                                  : tbl_data[7:0];
        else if (ex && wr_r && rsel != RA_PC && rsel != RA_STATUS)
            rf[rsel] <= res;
        if (ex && ioc_wr)
            ioc[ioc_idx] <= acc_r;
        if (ex && push)
            stack[sp_r] <= push_val;
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign pmem_addr       = pc_r;
    assign tbl_addr        = tbl_addr_r;
    assign sleep_out       = sleep_r;
    assign int_enable      = int_en_r;
    assign wdt_timeout     = wdt_to_r;
    assign cycle_end       = cyc_end_r;

endmodule : core_exec

/* File: tb/prog_mem.sv */
// Program memory model answering fetch and table reads one clock late
`timescale 1ns/1ps
module prog_mem
(
    input  wire logic        clk,       // Core clock
    input  wire logic [12:0] pmem_addr, // Fetch address
    output logic      [12:0] pmem_data, // Fetched word
    input  wire logic [12:0] tbl_addr,  // Table address
    output logic      [12:0] tbl_data   // Table word
);
    logic [12:0] mem [0:8191];

    initial
    begin
        foreach (mem[i]) mem[i] = 13'h0000;
        pmem_data = 13'h1555;
        tbl_data  = 13'h0AAA;
    end

    // Registered read, so a word is only valid one clock after its address
    always @(posedge clk)
    begin
        pmem_data <= mem[pmem_addr];
        tbl_data  <= mem[tbl_addr];
    end
endmodule : prog_mem

/* File: tb/core_exec_chk.sv */
// Port-level assertions for the instruction execution core
`timescale 1ns/1ps
module core_exec_chk
(
    input wire logic        clk,             // Core clock
    input wire logic        rst_b,           // Reset, active low
    input wire logic [3:0]  avs_address,     // Bus address
    input wire logic        avs_read,        // Bus read
    input wire logic        avs_write,       // Bus write
    input wire logic [31:0] avs_readdata,    // Bus read data
    input wire logic        avs_waitrequest, // Bus wait
    input wire logic [12:0] pmem_addr,       // Fetch address
    input wire logic        sleep_out,       // Stopped flag
    input wire logic        wdt_timeout,     // Watchdog pulse
    input wire logic        cycle_end        // Cycle end pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    wire req_w      = avs_read || avs_write;
    wire unmapped_w = !(avs_address inside {4'h0, 4'h4, 4'h8});

    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    chk_bus_answer: assert property (req_w && avs_waitrequest |=> s_answer)
        else $error("bus answer not a single wait cycle");
    chk_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(req_w))
        else $error("wait dropped without a request");
    chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && unmapped_w
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    chk_data_stands: assert property ($changed(avs_readdata)
        |-> $fell(avs_waitrequest) && avs_read) else $error("read data moved");
    chk_cycle_pulse: assert property (cycle_end |=> !cycle_end)
        else $error("cycle end pulse too long");
    chk_pc_stands: assert property ($changed(pmem_addr) |=> $stable(pmem_addr))
        else $error("fetch address stepped twice in a row");
    chk_sleep_freeze: assert property (sleep_out [*3] |-> $stable(pmem_addr))
        else $error("fetch moved while stopped");
    chk_wdt_pulse: assert property (wdt_timeout |=> !wdt_timeout)
        else $error("watchdog pulse too long");
endmodule : core_exec_chk

bind core_exec core_exec_chk core_exec_chk_i
(
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pmem_addr(pmem_addr),
    .sleep_out(sleep_out), .wdt_timeout(wdt_timeout), .cycle_end(cycle_end)
);

/* File: tb/core_exec_tb_top.sv */
// Self-checking bench for the instruction execution core
`timescale 1ns/1ps
module core_exec_tb_top;
    import core_exec_pkg::*;
    typedef struct { logic [1:0] psel; int gap; } prow_t;
    logic        clk, rst_b, avs_read, avs_write, avs_waitrequest, wake_pin;
    logic        sleep_out, int_enable, wdt_timeout, cycle_end;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [12:0] pmem_addr, pmem_data, tbl_addr, tbl_data;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          n;
    // No timer sits in this block, so the four-clock row needs no timer source setup
    prow_t       rows [4] = '{'{2'h0, 4}, '{2'h1, 2}, '{2'h2, 8}, '{2'h3, 16}};
    // Call, literal exit, move, add, rotate, sleep; no bit-set on interrupt status
    logic [12:0] prog [6] = '{13'h1EA0, 13'h0010, 13'h0050, 13'h1FA6, 13'h0690, 13'h0003};

    core_exec core_exec_i
    (
        .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
        .tbl_addr(tbl_addr), .tbl_data(tbl_data), .wake_pin(wake_pin),
        .sleep_out(sleep_out), .int_enable(int_enable), .wdt_timeout(wdt_timeout),
        .cycle_end(cycle_end)
    );

    prog_mem prog_mem_i
    (
        .clk(clk), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
        .tbl_addr(tbl_addr), .tbl_data(tbl_data)
    );

    always #12.5 clk = ~clk;

    task automatic close_out;
        if (miscompares == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Holds the request until waitrequest is sampled low, then releases it
    task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wd);
        avs_address   <= addr;
        avs_writedata <= wd;
        avs_write     <= wr;
        avs_read      <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            close_out();
        end
    end

    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'h1;
        avs_writedata = 32'h0;
        wake_pin = 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        bus(1'b0, OFF_CTRL, 32'h0);
        check("ctrl reset", 32'h0, rd);
        bus(1'b0, 4'hC, 32'h0);
        check("unmapped read", 32'h0, rd);
        foreach (rows[i])
        begin
            bus(1'b1, OFF_CTRL, {29'h0, 1'b1, rows[i].psel});
            repeat (2) @(posedge clk iff cycle_end === 1'b1);
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (cycle_end !== 1'b1);
            check("cycle gap", 32'(rows[i].gap), 32'(n));
        end
        foreach (prog[i]) prog_mem_i.mem[i] = prog[i];
        prog_mem_i.mem[16] = 13'h1C5A;
        // Reset while the core is running at the slowest period
        rst_b <= 1'b0;
        repeat (6) @(posedge clk);
        check("fetch at reset", 32'h0, {19'h0, pmem_addr});
        check("table address at reset", 32'h0, {19'h0, tbl_addr});
        rst_b <= 1'b1;
        @(posedge clk);
        bus(1'b1, OFF_CTRL, 32'h5);
        @(posedge clk iff sleep_out === 1'b1);
        bus(1'b0, OFF_ACC, 32'h0);
        check("acc and flags", 32'h6B5, rd & 32'h7FF);
        bus(1'b0, OFF_CORE, 32'h0);
        check("sleep and stack", 32'h10000, rd & 32'h1D0000);
        check("int enable", 32'h0, {31'h0, int_enable});
        // Watchdog on while stopped: expiry must pulse, wake the core and clear T
        bus(1'b1, OFF_CTRL, 32'hD);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wdt_timeout !== 1'b1);
        check("watchdog span", 32'h1,
              32'((n > 2 * int'(WDT_LAST)) && (n <= 2 * int'(WDT_LAST) + 2)));
        check("wake on timeout", 32'h0, {31'h0, sleep_out});
        bus(1'b0, OFF_ACC, 32'h0);
        check("timeout flag", 32'h0, {31'h0, rd[12]});
        close_out();
    end
endmodule : core_exec_tb_top
